// file: common/fcg_consts.svh
`ifndef FCG_CONSTS_SVH
`define FCG_CONSTS_SVH

// Register byte addresses
`define FCG_ADDR_CTRL 8'h00
`define FCG_ADDR_PATTERN 8'h04
`define FCG_ADDR_ALARM 8'h08
`define FCG_ADDR_USERWORD 8'h0C
`define FCG_ADDR_SEQID 8'h10
`define FCG_ADDR_XCHGID 8'h14
`define FCG_ADDR_SRCID 8'h18
`define FCG_ADDR_DSTID 8'h1C
`define FCG_ADDR_CREDIT 8'h20
`define FCG_ADDR_FRAMELEN 8'h24
`define FCG_ADDR_STATUS 8'h28
`define FCG_ADDR_ACCUM 8'h2C

// Control field positions
`define FCG_CTRL_FULL 0
`define FCG_CTRL_TOPO_LO 1
`define FCG_CTRL_LOGIN 3
`define FCG_CTRL_FLOWEN 4
`define FCG_CTRL_MEASSTART 5
`define FCG_CTRL_MODE_LO 8

// Port modes
`define FCG_MODE_OFF 3'h0
`define FCG_MODE_10G 3'h5

// Reset values
`define FCG_RST_FRAMELEN 12'h080
`define FCG_RST_CREDIT 8'h01

// Ordered sets and fixed words
`define FCG_OS_IDLE 32'hBC95B5B5
`define FCG_OS_LR 32'hBC49BF49
`define FCG_OS_LRR 32'hBC35BF49
`define FCG_OS_NOS 32'hBC55BF45
`define FCG_OS_OLS 32'hBC358A55
`define FCG_OS_SOF 32'hBCB55656
`define FCG_OS_EOF 32'hBC957575
`define FCG_K_FIRST 4'h8
`define FCG_K_NONE 4'h0

// Fixed header fields
`define FCG_HDR_RCTL 8'h00
`define FCG_HDR_CSCTL 8'h00
`define FCG_HDR_TYPE 8'hE0
`define FCG_HDR_FCTL 24'h380000
`define FCG_HDR_DFCTL 8'h00
`define FCG_HDR_PARM 32'h00000000
`define FCG_HDR_WORDS 3'h6

// Payload fills and frame CRC constants
`define FCG_WORD_ALT 32'h55555555
`define FCG_WORD_ZERO 32'h00000000
`define FCG_WORD_HFREQ 32'hB5B5B5B5
`define FCG_WORD_JITTER 32'h7E7E7E74
`define FCG_WORD_NOISE 32'h7F7F7F7F
`define FCG_CRC_INIT 32'hFFFFFFFF
`define FCG_CRC_POLY 32'h04C11DB7
`define FCG_TEXT_LEN 6'h37
`define FCG_TEXT "The quick brown fox jumped over the lazy dog 1234567890"

`endif

// file: common/fcg_pkg.sv
package fcg_pkg;

  typedef enum logic [6:0] {
    TX_IDLE = 7'b0000001,
    TX_SOF = 7'b0000010,
    TX_HDR = 7'b0000100,
    TX_PAY = 7'b0001000,
    TX_CRC = 7'b0010000,
    TX_EOF = 7'b0100000,
    TX_ALARM = 7'b1000000
  } fcg_tx_state_t;

  typedef enum logic [3:0] {
    PAY_TEXT = 4'h0,
    PAY_ALT = 4'h1,
    PAY_PRBS = 4'h2,
    PAY_HIGH_TOGGLE = 4'h3,
    PAY_COMPLIANT = 4'h4,
    PAY_JITTER = 4'h5,
    PAY_SUPPLY_NOISE = 4'h6,
    PAY_USER = 4'h7,
    PAY_ZERO = 4'h8
  } fcg_payload_t;

  typedef enum logic [2:0] {
    ALM_NONE = 3'h0,
    ALM_LINK_RESET = 3'h1,
    ALM_LINK_RESET_RESP = 3'h2,
    ALM_NOT_OPER = 3'h3,
    ALM_OFFLINE = 3'h4
  } fcg_alarm_t;

  typedef enum logic [1:0] {
    TOPO_PTP = 2'h0,
    TOPO_FABRIC = 2'h1,
    TOPO_EPORT = 2'h2
  } fcg_topo_t;

endpackage : fcg_pkg

// file: hdl/fcg_frame_generator.sv
`timescale 1ns/1ps
`include "fcg_consts.svh"

module fcg_frame_generator #(
  parameter int FRAME_LEN_W = 12,
  parameter int CREDIT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Transmit word stream to the line coder
  output logic [31:0] txData,
  output logic [3:0] txCharK,
  output logic txCoding64b,
  output logic txActive,
  // Receive indications from pins
  input wire logic rxSignalDet,
  input wire logic rxWordSync,
  input wire logic rxFabricLogin,
  input wire logic rxLinkParamDone,
  input wire logic rxPortLogin,
  input wire logic rxTraffic,
  input wire logic rxPatSync,
  input wire logic rxPatErr,
  input wire logic rxReady,
  input wire logic rxBitEarly,
  input wire logic rxBitLate
);

  initial begin
    if (FRAME_LEN_W < 4 || FRAME_LEN_W > 16) $error("FRAME_LEN_W out of range");
    if (CREDIT_W < 2 || CREDIT_W > 8) $error("CREDIT_W out of range");
  end

  localparam logic [8*55-1:0] TEXT = `FCG_TEXT;

  // Configuration registers
  logic fullFraming_ff;
  fcg_pkg::fcg_topo_t topo_ff;
  logic login_ff;
  logic flowEn_ff;
  logic [2:0] portMode_ff;
  fcg_pkg::fcg_payload_t paySel_ff;
  logic [4:0] prbsOrder_ff;
  fcg_pkg::fcg_alarm_t alarmSel_ff;
  logic [31:0] userWord_ff;
  logic [7:0] seqId_ff;
  logic [15:0] oxId_ff;
  logic [15:0] rxId_ff;
  logic [23:0] srcId_ff;
  logic [23:0] dstId_ff;
  logic [CREDIT_W-1:0] remoteCredit_ff;
  logic [CREDIT_W-1:0] localCredit_ff;
  logic [CREDIT_W-1:0] peerCredit_ff;
  logic [FRAME_LEN_W-1:0] frameLen_ff;
  logic measStart;

  // Synchronisers for pin inputs
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] syncIn;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic rdyPrev_ff;
  logic earlyPrev_ff;
  logic latePrev_ff;

  assign syncIn = {rxBitLate, rxBitEarly, rxReady, rxPatErr, rxPatSync, rxTraffic,
                   rxPortLogin, rxLinkParamDone, rxFabricLogin, rxWordSync, rxSignalDet};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : gSync
      always_ff @(posedge clk) begin
        if (rst) begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
        end else begin
          sync1_ff[g] <= syncIn[g];
          sync2_ff[g] <= sync1_ff[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      rdyPrev_ff <= 1'b0;
      earlyPrev_ff <= 1'b0;
      latePrev_ff <= 1'b0;
    end else begin
      rdyPrev_ff <= sync2_ff[8];
      earlyPrev_ff <= sync2_ff[9];
      latePrev_ff <= sync2_ff[10];
    end
  end

  logic rdyPulse;
  logic earlyPulse;
  logic latePulse;
  assign rdyPulse = sync2_ff[8] & ~rdyPrev_ff;
  assign earlyPulse = sync2_ff[9] & ~earlyPrev_ff;
  assign latePulse = sync2_ff[10] & ~latePrev_ff;

  // Register writes
  assign measStart = regWr && regAddr == `FCG_ADDR_CTRL && regWrData[`FCG_CTRL_MEASSTART];

  always_ff @(posedge clk) begin
    if (rst) begin
      fullFraming_ff <= 1'b0;
      topo_ff <= fcg_pkg::TOPO_PTP;
      login_ff <= 1'b0;
      flowEn_ff <= 1'b0;
      portMode_ff <= `FCG_MODE_OFF;
      paySel_ff <= fcg_pkg::PAY_TEXT;
      prbsOrder_ff <= 5'h09;
      alarmSel_ff <= fcg_pkg::ALM_NONE;
      userWord_ff <= 32'h0;
      seqId_ff <= 8'h00;
      oxId_ff <= 16'h0000;
      rxId_ff <= 16'hFFFF;
      srcId_ff <= 24'h000000;
      dstId_ff <= 24'h000000;
      remoteCredit_ff <= CREDIT_W'(`FCG_RST_CREDIT);
      localCredit_ff <= CREDIT_W'(`FCG_RST_CREDIT);
      peerCredit_ff <= CREDIT_W'(`FCG_RST_CREDIT);
      frameLen_ff <= FRAME_LEN_W'(`FCG_RST_FRAMELEN);
    end else if (regWr) begin
      unique case (regAddr)
        `FCG_ADDR_CTRL: begin
          fullFraming_ff <= regWrData[`FCG_CTRL_FULL];
          topo_ff <= fcg_pkg::fcg_topo_t'(regWrData[`FCG_CTRL_TOPO_LO +: 2]);
          login_ff <= regWrData[`FCG_CTRL_LOGIN];
          flowEn_ff <= regWrData[`FCG_CTRL_FLOWEN];
          portMode_ff <= regWrData[`FCG_CTRL_MODE_LO +: 3];
        end
        `FCG_ADDR_PATTERN: begin
          paySel_ff <= fcg_pkg::fcg_payload_t'(regWrData[3:0]);
          prbsOrder_ff <= regWrData[12:8];
        end
        `FCG_ADDR_ALARM: alarmSel_ff <= fcg_pkg::fcg_alarm_t'(regWrData[2:0]);
        `FCG_ADDR_USERWORD: userWord_ff <= regWrData;
        `FCG_ADDR_SEQID: seqId_ff <= regWrData[7:0];
        `FCG_ADDR_XCHGID: begin
          oxId_ff <= regWrData[31:16];
          rxId_ff <= regWrData[15:0];
        end
        `FCG_ADDR_SRCID: srcId_ff <= regWrData[23:0];
        `FCG_ADDR_DSTID: dstId_ff <= regWrData[23:0];
        `FCG_ADDR_CREDIT: begin
          remoteCredit_ff <= regWrData[CREDIT_W-1:0];
          localCredit_ff <= regWrData[8 +: CREDIT_W];
          peerCredit_ff <= regWrData[16 +: CREDIT_W];
        end
        `FCG_ADDR_FRAMELEN: frameLen_ff <= regWrData[FRAME_LEN_W-1:0];
        default: ;
      endcase
    end
  end

  // Derived modes
  logic effFull;
  logic creditGate;
  logic [CREDIT_W-1:0] creditLimit;
  logic [CREDIT_W-1:0] outstanding_ff;
  logic linkOn;
  assign linkOn = portMode_ff != `FCG_MODE_OFF;
  assign effFull = fullFraming_ff || topo_ff == fcg_pkg::TOPO_FABRIC
                   || (topo_ff == fcg_pkg::TOPO_PTP && login_ff);
  assign creditLimit = login_ff ? peerCredit_ff : remoteCredit_ff;
  assign creditGate = flowEn_ff && topo_ff == fcg_pkg::TOPO_PTP
                      && outstanding_ff >= creditLimit;

  // Transmit sequencer
  fcg_pkg::fcg_tx_state_t state_ff;
  logic [2:0] hdrIdx_ff;
  logic [FRAME_LEN_W-1:0] payCnt_ff;
  logic [31:0] payWord;
  logic [31:0] hdrWord;
  logic [31:0] crc_ff;
  logic [31:0] prbs_ff;
  logic [5:0] textIdx_ff;
  logic [1:0] tblIdx_ff;
  logic frameStart;
  logic frameFull_ff;

  assign frameStart = state_ff == fcg_pkg::TX_SOF;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= fcg_pkg::TX_IDLE;
      frameFull_ff <= 1'b0;
      hdrIdx_ff <= 3'h0;
      payCnt_ff <= '0;
    end else begin
      unique case (state_ff)
        fcg_pkg::TX_IDLE: begin
          if (linkOn && alarmSel_ff != fcg_pkg::ALM_NONE)
            state_ff <= fcg_pkg::TX_ALARM;
          else if (linkOn && !creditGate) begin
            state_ff <= fcg_pkg::TX_SOF;
            // Framing is fixed per frame so a control write cannot cut a header or CRC
            frameFull_ff <= effFull;
          end
        end
        fcg_pkg::TX_ALARM: begin
          if (alarmSel_ff == fcg_pkg::ALM_NONE || !linkOn) state_ff <= fcg_pkg::TX_IDLE;
        end
        fcg_pkg::TX_SOF: begin
          hdrIdx_ff <= 3'h0;
          payCnt_ff <= '0;
          state_ff <= frameFull_ff ? fcg_pkg::TX_HDR : fcg_pkg::TX_PAY;
        end
        fcg_pkg::TX_HDR: begin
          hdrIdx_ff <= hdrIdx_ff + 3'h1;
          if (hdrIdx_ff == `FCG_HDR_WORDS - 3'h1) state_ff <= fcg_pkg::TX_PAY;
        end
        fcg_pkg::TX_PAY: begin
          payCnt_ff <= payCnt_ff + 1'b1;
          if (payCnt_ff == frameLen_ff - 1'b1)
            state_ff <= frameFull_ff ? fcg_pkg::TX_CRC : fcg_pkg::TX_EOF;
        end
        fcg_pkg::TX_CRC: state_ff <= fcg_pkg::TX_EOF;
        fcg_pkg::TX_EOF: state_ff <= fcg_pkg::TX_IDLE;
      endcase
    end
  end

  // Header words
  always_comb begin
    unique case (hdrIdx_ff)
      3'h0: hdrWord = {`FCG_HDR_RCTL, dstId_ff};
      3'h1: hdrWord = {`FCG_HDR_CSCTL, srcId_ff};
      3'h2: hdrWord = {`FCG_HDR_TYPE, `FCG_HDR_FCTL};
      3'h3: hdrWord = {seqId_ff, `FCG_HDR_DFCTL, 16'(payCnt_ff)};
      3'h4: hdrWord = {oxId_ff, rxId_ff};
      default: hdrWord = `FCG_HDR_PARM;
    endcase
  end

  // Pseudo-random step: 32 serial shifts of a Fibonacci register of the chosen order
  function automatic logic [31:0] prbsStep(input logic [31:0] s, input logic [4:0] ord);
    logic [31:0] r;
    logic fb;
    r = s;
    for (int i = 0; i < 32; i++) begin
      unique case (ord)
        5'd11: fb = r[10] ^ r[8];
        5'd15: fb = r[14] ^ r[13];
        5'd20: fb = r[19] ^ r[2];
        5'd23: fb = r[22] ^ r[17];
        5'd29: fb = r[28] ^ r[26];
        5'd31: fb = r[30] ^ r[27];
        default: fb = r[8] ^ r[4];
      endcase
      r = {r[30:0], fb};
    end
    return r;
  endfunction : prbsStep

  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      if (r[31] ^ d[i]) r = {r[30:0], 1'b0} ^ `FCG_CRC_POLY;
      else r = {r[30:0], 1'b0};
    end
    return r;
  endfunction : crcStep

  logic [31:0] prbsNext;
  logic [31:0] prbsMask;
  logic [4:0] prbsLen;
  // Orders without taps of their own run the order-9 register, so the kept state follows those taps
  assign prbsLen = prbsOrder_ff inside {5'd11, 5'd15, 5'd20, 5'd23, 5'd29, 5'd31} ? prbsOrder_ff : 5'd9;
  assign prbsNext = prbsStep(prbs_ff, prbsOrder_ff);
  assign prbsMask = (32'h1 << prbsLen) - 32'h1;

  // Payload source
  always_comb begin
    unique case (paySel_ff)
      fcg_pkg::PAY_TEXT: payWord = {TEXT[8*(54-textIdx_ff) +: 8],
                                    TEXT[8*(54-((textIdx_ff+6'd1)%`FCG_TEXT_LEN)) +: 8],
                                    TEXT[8*(54-((textIdx_ff+6'd2)%`FCG_TEXT_LEN)) +: 8],
                                    TEXT[8*(54-((textIdx_ff+6'd3)%`FCG_TEXT_LEN)) +: 8]};
      fcg_pkg::PAY_ALT: payWord = `FCG_WORD_ALT;
      fcg_pkg::PAY_PRBS: payWord = prbsNext;
      fcg_pkg::PAY_HIGH_TOGGLE: payWord = `FCG_WORD_HFREQ;
      fcg_pkg::PAY_COMPLIANT: payWord = prbsNext ^ {tblIdx_ff, 30'h0};
      fcg_pkg::PAY_JITTER: payWord = tblIdx_ff[1] ? ~`FCG_WORD_JITTER : `FCG_WORD_JITTER;
      fcg_pkg::PAY_SUPPLY_NOISE: payWord = tblIdx_ff[0] ? ~`FCG_WORD_NOISE : `FCG_WORD_NOISE;
      fcg_pkg::PAY_USER: payWord = userWord_ff;
      default: payWord = `FCG_WORD_ZERO;
    endcase
  end

  // Payload pattern state advances only on payload words
  always_ff @(posedge clk) begin
    if (rst) begin
      prbs_ff <= 32'hFFFFFFFF;
      textIdx_ff <= 6'h0;
      tblIdx_ff <= 2'h0;
    end else if (state_ff == fcg_pkg::TX_SOF) begin
      tblIdx_ff <= 2'h0;
    end else if (state_ff == fcg_pkg::TX_PAY) begin
      // An all-zero state would lock the register, as after a switch to a shorter order
      prbs_ff <= (prbsNext & prbsMask) != 32'h0 ? prbsNext & prbsMask : 32'hFFFFFFFF;
      textIdx_ff <= 6'((textIdx_ff + 6'd4) % `FCG_TEXT_LEN);
      tblIdx_ff <= tblIdx_ff + 2'h1;
    end
  end

  // Frame CRC over header and payload
  always_ff @(posedge clk) begin
    if (rst) crc_ff <= `FCG_CRC_INIT;
    else if (state_ff == fcg_pkg::TX_SOF) crc_ff <= `FCG_CRC_INIT;
    else if (state_ff == fcg_pkg::TX_HDR) crc_ff <= crcStep(crc_ff, hdrWord);
    else if (state_ff == fcg_pkg::TX_PAY) crc_ff <= crcStep(crc_ff, payWord);
  end

  // Output word
  always_ff @(posedge clk) begin
    if (rst) begin
      txData <= `FCG_OS_IDLE;
      txCharK <= `FCG_K_FIRST;
      txActive <= 1'b0;
      txCoding64b <= 1'b0;
    end else begin
      txCoding64b <= portMode_ff == `FCG_MODE_10G;
      txActive <= linkOn;
      unique case (state_ff)
        fcg_pkg::TX_SOF: begin
          txData <= `FCG_OS_SOF;
          txCharK <= `FCG_K_FIRST;
        end
        fcg_pkg::TX_HDR: begin
          txData <= hdrWord;
          txCharK <= `FCG_K_NONE;
        end
        fcg_pkg::TX_PAY: begin
          txData <= payWord;
          txCharK <= `FCG_K_NONE;
        end
        fcg_pkg::TX_CRC: begin
          txData <= ~crc_ff;
          txCharK <= `FCG_K_NONE;
        end
        fcg_pkg::TX_EOF: begin
          txData <= `FCG_OS_EOF;
          txCharK <= `FCG_K_FIRST;
        end
        fcg_pkg::TX_ALARM: begin
          txCharK <= `FCG_K_FIRST;
          unique case (alarmSel_ff)
            fcg_pkg::ALM_LINK_RESET: txData <= `FCG_OS_LR;
            fcg_pkg::ALM_LINK_RESET_RESP: txData <= `FCG_OS_LRR;
            fcg_pkg::ALM_NOT_OPER: txData <= `FCG_OS_NOS;
            fcg_pkg::ALM_OFFLINE: txData <= `FCG_OS_OLS;
            default: txData <= `FCG_OS_IDLE;
          endcase
        end
        default: begin
          txData <= `FCG_OS_IDLE;
          txCharK <= `FCG_K_FIRST;
        end
      endcase
    end
  end

  // Outstanding frames: a start and a returned ready in the same cycle cancel
  always_ff @(posedge clk) begin
    if (rst || measStart) outstanding_ff <= '0;
    else if (frameStart && !rdyPulse) outstanding_ff <= outstanding_ff + 1'b1;
    else if (!frameStart && rdyPulse && outstanding_ff != '0) outstanding_ff <= outstanding_ff - 1'b1;
  end

  // Accumulated bit-count difference
  logic signed [31:0] accum_ff;
  always_ff @(posedge clk) begin
    if (rst || measStart) accum_ff <= '0;
    else if (earlyPulse && !latePulse) accum_ff <= accum_ff + 32'sd1;
    else if (latePulse && !earlyPulse) accum_ff <= accum_ff - 32'sd1;
  end

  // Status word
  logic [31:0] status;
  assign status = {8'(localCredit_ff), 8'(outstanding_ff), 8'h00,
                   sync2_ff[7], sync2_ff[6], sync2_ff[5],
                   sync2_ff[4], sync2_ff[3], sync2_ff[2],
                   sync2_ff[1], sync2_ff[0]};

  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) regRdData <= 32'h0;
    else if (regRd) begin
      unique case (regAddr)
        `FCG_ADDR_CTRL: regRdData <= {21'h0, portMode_ff, 3'h0, flowEn_ff, login_ff, topo_ff, fullFraming_ff};
        `FCG_ADDR_PATTERN: regRdData <= {19'h0, prbsOrder_ff, 4'h0, paySel_ff};
        `FCG_ADDR_ALARM: regRdData <= {29'h0, alarmSel_ff};
        `FCG_ADDR_USERWORD: regRdData <= userWord_ff;
        `FCG_ADDR_SEQID: regRdData <= {24'h0, seqId_ff};
        `FCG_ADDR_XCHGID: regRdData <= {oxId_ff, rxId_ff};
        `FCG_ADDR_SRCID: regRdData <= {8'h0, srcId_ff};
        `FCG_ADDR_DSTID: regRdData <= {8'h0, dstId_ff};
        `FCG_ADDR_CREDIT: regRdData <= {8'h0, 8'(peerCredit_ff), 8'(localCredit_ff), 8'(remoteCredit_ff)};
        `FCG_ADDR_FRAMELEN: regRdData <= 32'(frameLen_ff);
        `FCG_ADDR_STATUS: regRdData <= status;
        `FCG_ADDR_ACCUM: regRdData <= accum_ff;
        default: regRdData <= 32'h0;
      endcase
    end else regRdData <= 32'h0;
  end

endmodule : fcg_frame_generator

// file: tb/fcg_peer_model.sv
`timescale 1ns/1ps
`include "fcg_consts.svh"
module fcg_peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stream from the port under test
  input wire logic [31:0] txData,
  input wire logic [3:0] txCharK,
  // Credit return, held back while stall is high
  input wire logic stall,
  output logic rxReady
);
  logic [7:0] owed_ff;
  logic give;
  // Pulses spaced apart so each returned credit is its own rising edge
  assign give = !rxReady && !stall && owed_ff != 8'h00;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxReady <= 1'b0;
    end else begin
      rxReady <= give;
    end
  end
  // One receive buffer freed per frame end seen
  always_ff @(posedge clk) begin
    if (rst) begin
      owed_ff <= 8'h00;
    end else begin
      owed_ff <= owed_ff + 8'(txData == `FCG_OS_EOF && txCharK == `FCG_K_FIRST) - 8'(give);
    end
  end
endmodule : fcg_peer_model

// file: tb/fcg_frame_generator_sva.sv
`timescale 1ns/1ps
`include "fcg_consts.svh"
module fcg_frame_generator_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic [31:0] regRdData,
  // Transmit stream
  input wire logic [31:0] txData,
  input wire logic [3:0] txCharK,
  input wire logic txCoding64b,
  input wire logic txActive
);
  logic isOs, isSof, isEof, isAlarm, wrCtrl, wrAlarm, full_ff;
  logic [11:0] len_ff;
  logic [12:0] cnt_ff;
  assign isOs = txCharK == `FCG_K_FIRST;
  assign isSof = isOs && txData == `FCG_OS_SOF;
  assign isEof = isOs && txData == `FCG_OS_EOF;
  assign isAlarm = isOs && txData inside {`FCG_OS_LR, `FCG_OS_LRR, `FCG_OS_NOS, `FCG_OS_OLS};
  assign wrCtrl = regWr && regAddr == `FCG_ADDR_CTRL;
  assign wrAlarm = regWr && regAddr == `FCG_ADDR_ALARM;
  // Framing follows writes that enable the port; an off write leaves it, so a frame in flight keeps it
  always_ff @(posedge clk) begin
    if (rst) begin
      full_ff <= 1'b0;
    end else if (wrCtrl && regWrData[10:8] != `FCG_MODE_OFF) begin
      full_ff <= regWrData[0] || regWrData[2:1] == 2'h1 || (regWrData[2:1] == 2'h0 && regWrData[3]);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      len_ff <= `FCG_RST_FRAMELEN;
    end else if (regWr && regAddr == `FCG_ADDR_FRAMELEN) begin
      len_ff <= regWrData[11:0];
    end
  end
  // Data words since the last start delimiter
  always_ff @(posedge clk) begin
    if (rst || isSof) begin
      cnt_ff <= 13'h0000;
    end else if (txCharK == `FCG_K_NONE) begin
      cnt_ff <= cnt_ff + 13'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_idle;
    $fell(rst) |-> isOs && txData == `FCG_OS_IDLE && !txActive && !txCoding64b && regRdData == 32'h0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_eof_idle;
    isEof |=> isOs && txData == `FCG_OS_IDLE;
  endproperty
  a_eof_idle: assert property (p_eof_idle) else $error("no idle after end delimiter");
  property p_sof_data;
    isSof |=> txCharK == `FCG_K_NONE;
  endproperty
  a_sof_data: assert property (p_sof_data) else $error("start delimiter not followed by data");
  property p_os_k;
    isOs |-> txData inside {`FCG_OS_IDLE, `FCG_OS_SOF, `FCG_OS_EOF, `FCG_OS_LR, `FCG_OS_LRR, `FCG_OS_NOS, `FCG_OS_OLS};
  endproperty
  a_os_k: assert property (p_os_k) else $error("unknown ordered set");
  property p_alarm_hold;
    isAlarm && !wrAlarm && !$past(wrAlarm) |=> isOs && $stable(txData);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm sequence interrupted");
  property p_coding;
    wrCtrl |=> ##1 txCoding64b == ($past(regWrData[10:8], 2) == `FCG_MODE_10G)
      && txActive == ($past(regWrData[10:8], 2) != `FCG_MODE_OFF);
  endproperty
  a_coding: assert property (p_coding) else $error("coding or active flag wrong");
  property p_bare_len;
    isEof && !full_ff |-> cnt_ff == {1'b0, len_ff};
  endproperty
  a_bare_len: assert property (p_bare_len) else $error("bare frame length wrong");
  property p_full_len;
    isEof && full_ff |-> cnt_ff == {1'b0, len_ff} + 13'h0007;
  endproperty
  a_full_len: assert property (p_full_len) else $error("full frame length wrong");
  c_full: cover property (isEof && full_ff);
  c_bare: cover property (isEof && !full_ff);
  c_alarm: cover property (isAlarm);
endmodule : fcg_frame_generator_sva
bind fcg_frame_generator fcg_frame_generator_sva i_sva (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRdData(regRdData), .txData(txData), .txCharK(txCharK),
  .txCoding64b(txCoding64b), .txActive(txActive));

// file: tb/fcg_frame_generator_test.sv
`timescale 1ns/1ps
`include "fcg_consts.svh"
module fcg_frame_generator_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData, txData, rdv;
  logic [3:0] txCharK;
  logic txCoding64b, txActive, rxReady, ok, m;
  logic rxBitEarly = 1'b0;
  logic rxBitLate = 1'b0;
  logic stall = 1'b1;
  logic [7:0] rxSt = 8'h00;
  logic [31:0] wbuf [0:63];
  logic [31:0] ev [0:6];
  logic [7:0] ra [0:4] = '{`FCG_ADDR_CTRL, `FCG_ADDR_FRAMELEN, `FCG_ADDR_CREDIT, `FCG_ADDR_XCHGID, 8'h3C};
  logic [31:0] rv [0:4] = '{32'h0, 32'h80, 32'h00010101, 32'h0000FFFF, 32'h0};
  logic [3:0] pp [0:6] = '{4'h1, 4'h8, 4'h3, 4'h5, 4'h6, 4'h7, 4'h4};
  logic [31:0] pw [0:5] = '{`FCG_WORD_ALT, `FCG_WORD_ZERO, `FCG_WORD_HFREQ, `FCG_WORD_JITTER, `FCG_WORD_NOISE,
    32'hCAFEF00D};
  logic [31:0] os [1:4] = '{`FCG_OS_LR, `FCG_OS_LRR, `FCG_OS_NOS, `FCG_OS_OLS};
  string txt = `FCG_TEXT;
  int fails = 0;
  int checks = 0;
  int n, i, k, o;
  always #2 clk = ~clk;
  fcg_frame_generator i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .txData(txData), .txCharK(txCharK), .txCoding64b(txCoding64b),
    .txActive(txActive), .rxSignalDet(rxSt[0]), .rxWordSync(rxSt[1]), .rxFabricLogin(rxSt[2]),
    .rxLinkParamDone(rxSt[3]), .rxPortLogin(rxSt[4]), .rxTraffic(rxSt[5]), .rxPatSync(rxSt[6]),
    .rxPatErr(rxSt[7]), .rxReady(rxReady), .rxBitEarly(rxBitEarly), .rxBitLate(rxBitLate));
  fcg_peer_model i_peer (.clk(clk), .rst(rst), .txData(txData), .txCharK(txCharK), .stall(stall),
    .rxReady(rxReady));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Everything runs 1 ns after the edge so outputs are settled
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    tick(1);
    regWr <= 1'b0;
    tick(1);
  endtask : wr
  task rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    tick(1);
    regRd <= 1'b0;
    rdv = regRdData;
    tick(1);
  endtask : rd
  task cfg(input logic [31:0] len, input logic [31:0] pat);
    wr(`FCG_ADDR_CTRL, 32'h0);
    tick(80);
    wr(`FCG_ADDR_FRAMELEN, len);
    wr(`FCG_ADDR_PATTERN, pat);
  endtask : cfg
  // Collect the data words of the next whole frame
  task grab;
    for (i = 0; i < 3000 && !(txData === `FCG_OS_SOF && txCharK === `FCG_K_FIRST); i++) tick(1);
    n = 0;
    for (k = 0; k < 64 && txData !== `FCG_OS_EOF; k++) begin
      tick(1);
      if (txData !== `FCG_OS_EOF) begin
        wbuf[n] = txData;
        n++;
      end
    end
    if (i == 3000 || k == 64) begin
      fails++;
      finish_test();
    end
  endtask : grab
  task cnt_sof(input int c);
    n = 0;
    repeat (c) begin
      tick(1);
      if (txData === `FCG_OS_SOF) n++;
    end
  endtask : cnt_sof
  initial begin
    tick(2);
    rst <= 1'b0;
    tick(1);
    for (o = 0; o < 5; o++) begin
      rd(ra[o]);
      chk("reset value", rv[o], rdv);
    end
    cfg(32'h4, 32'h1);
    wr(`FCG_ADDR_CREDIT, 32'h00010002);
    wr(`FCG_ADDR_CTRL, 32'h110);
    cnt_sof(300);
    chk("frames within remote credit", 32'h2, n);
    stall <= 1'b0;
    cnt_sof(300);
    chk("frames after credit return", 32'h1, 32'(n > 2));
    cfg(32'h4, 32'h1);
    stall <= 1'b1;
    wr(`FCG_ADDR_CTRL, 32'h138);
    cnt_sof(300);
    chk("frames within peer credit", 32'h1, n);
    cfg(32'h4, 32'h1);
    wr(`FCG_ADDR_CTRL, 32'h114);
    cnt_sof(300);
    chk("no credit wait outside ptp", 32'h1, 32'(n > 2));
    stall <= 1'b0;
    cfg(32'h1, 32'h7);
    wr(`FCG_ADDR_SEQID, 32'h5A);
    wr(`FCG_ADDR_XCHGID, 32'h1234ABCD);
    wr(`FCG_ADDR_SRCID, 32'h010203);
    wr(`FCG_ADDR_DSTID, 32'h0A0B0C);
    wr(`FCG_ADDR_USERWORD, 32'hCAFEF00D);
    ev = '{{`FCG_HDR_RCTL, 24'h0A0B0C}, {`FCG_HDR_CSCTL, 24'h010203}, {`FCG_HDR_TYPE, `FCG_HDR_FCTL},
      {8'h5A, `FCG_HDR_DFCTL, 16'h0000}, 32'h1234ABCD, `FCG_HDR_PARM, 32'hCAFEF00D};
    wr(`FCG_ADDR_CTRL, 32'h101);
    grab();
    chk("full frame words", 32'h8, n);
    for (o = 0; o < 7; o++) chk("header and payload", ev[o], wbuf[o]);
    wr(`FCG_ADDR_CTRL, 32'h102);
    grab();
    grab();
    chk("fabric frame words", 32'h8, n);
    for (o = 0; o < 7; o++) begin
      cfg(32'h2, {28'h0, pp[o]});
      wr(`FCG_ADDR_CTRL, 32'h100);
      grab();
      chk("bare frame words", 32'h2, n);
      if (o < 6) chk("first payload word", pw[o], wbuf[0]);
      if (o < 6) chk("second payload word", o == 4 ? ~pw[o] : pw[o], wbuf[1]);
    end
    cfg(32'hE, 32'h0);
    wr(`FCG_ADDR_CTRL, 32'h100);
    grab();
    ok = 1'b0;
    for (o = 0; o < 55; o++) begin
      m = 1'b1;
      for (k = 0; k < 56; k++) if (wbuf[k / 4][31 - 8 * (k % 4) -: 8] !== txt[(o + k) % 55]) m = 1'b0;
      ok = ok | m;
    end
    chk("text payload", 32'h1, {31'h0, ok});
    cfg(32'h28, 32'h0902);
    wr(`FCG_ADDR_CTRL, 32'h100);
    grab();
    n = 0;
    for (k = 0; k < 600; k++) n += (wbuf[k / 32][31 - k % 32] !== wbuf[(k + 511) / 32][31 - (k + 511) % 32]);
    chk("order 9 period mismatches", 32'h0, n);
    chk("order 9 not stuck", 32'h1, 32'(wbuf[0] != 32'h0));
    for (o = 1; o < 5; o++) begin
      wr(`FCG_ADDR_ALARM, o);
      for (k = 0; k < 300 && txData !== os[o]; k++) tick(1);
      if (txData !== os[o]) begin
        fails++;
        finish_test();
      end
      repeat (8) begin
        chk("alarm word", os[o], txData);
        tick(1);
      end
    end
    wr(`FCG_ADDR_ALARM, 32'h0);
    grab();
    chk("frames after alarm", 32'h28, n);
    for (o = 0; o < 8; o++) begin
      rxSt <= 8'(1 << o);
      tick(4);
      rd(`FCG_ADDR_STATUS);
      chk("status flags", 32'(1 << o), {24'h0, rdv[7:0]});
    end
    wr(`FCG_ADDR_CTRL, 32'h120);
    repeat (3) begin
      rxBitEarly <= 1'b1;
      tick(2);
      rxBitEarly <= 1'b0;
      tick(2);
    end
    rxBitLate <= 1'b1;
    tick(2);
    rxBitLate <= 1'b0;
    tick(6);
    rd(`FCG_ADDR_ACCUM);
    chk("bit count difference", 32'h2, rdv);
    wr(`FCG_ADDR_CTRL, 32'h120);
    rd(`FCG_ADDR_ACCUM);
    chk("difference after restart", 32'h0, rdv);
    wr(`FCG_ADDR_CTRL, 32'h500);
    tick(3);
    chk("block coding at top rate", 32'h1, {31'h0, txCoding64b});
    finish_test();
  end
endmodule : fcg_frame_generator_test
